//--- common/osc_time_if.sv
`timescale 1ns/1ps
`default_nettype none
interface osc_time_if;
	logic min_toggle;
	logic half_minute;
	logic [rtc_pkg::FREQ_COUNT-1:0] freq_level;
	logic lv_window;
	modport src (output min_toggle, output half_minute, output freq_level, output lv_window);
	modport dst (input min_toggle, input half_minute, input freq_level, input lv_window);
endinterface : osc_time_if
`default_nettype wire

//--- common/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
	// access command codes carried by the two-wire front end
	localparam logic [2:0] CMD_STATUS_ONE = 3'h0;
	localparam logic [2:0] CMD_STATUS_TWO = 3'h1;
	localparam logic [2:0] CMD_ALARM_ONE = 3'h4;
	localparam logic [2:0] CMD_ALARM_TWO = 3'h5;
	localparam logic [2:0] CMD_CORRECTION = 3'h6;
	localparam logic [2:0] CMD_FREE = 3'h7;

	// status_mode_one bit positions
	localparam int S1_POWER_ON = 0;
	localparam int S1_LOW_VOLT = 1;
	localparam int S1_ALARM_TWO = 2;
	localparam int S1_ALARM_ONE = 3;
	localparam int S1_SCRATCH_B = 4;
	localparam int S1_SCRATCH_A = 5;
	localparam int S1_HOUR_24 = 6;
	localparam int S1_INIT = 7;

	// status_mode_two bit positions
	localparam int S2_TEST = 0;
	localparam int S2_OUT2_ALARM = 1;
	localparam int S2_OUT2_MINUTE = 2;
	localparam int S2_OUT2_FREQ = 3;
	localparam int S2_SCRATCH_C = 4;
	localparam int S2_A1_ENABLE = 5;
	localparam int S2_A1_MINUTE = 6;
	localparam int S2_A1_FREQ = 7;

	// alarm byte compare enable and frequency select field
	localparam int ALARM_VALID_BIT = 0;
	localparam int ALARM_BYTES = 3;
	localparam int FREQ_FIELD_LSB = 3;
	localparam int FREQ_COUNT = 5;

	// power-on values; initialization clears everything else to zero
	localparam logic [7:0] RST_STATUS_TWO = 8'h80;
	localparam logic [7:0] RST_ALARM_ONE = 8'h80;
	localparam logic [7:0] RST_ALARM_TWO = 8'h00;
	localparam logic [7:0] RST_CORRECTION = 8'h00;
	localparam logic [7:0] RST_FREE = 8'h00;
	localparam logic [7:0] INIT_VALUE = 8'h00;

	// oscillator-domain timing
	localparam int OSC_HZ_DEFAULT = 32768;
	localparam real LV_SAMPLE_MS = 15.6;
	localparam int SECONDS_PER_MINUTE = 60;
	localparam int HALF_MINUTE = 30;

	typedef enum logic [4:0] {
		OUT2_NONE = 5'h01,
		OUT2_FREQ = 5'h02,
		OUT2_EDGE = 5'h04,
		OUT2_PERIODIC = 5'h08,
		OUT2_ALARM = 5'h10
	} out2_mode_t;
endpackage : rtc_pkg
`default_nettype wire

//--- hw/rtc_status_alarm_control.sv
// Summary of operation
// - power-on flag set at power-up, cleared once read, read-only.
// - low-voltage flag sets at or below detection and stays set after recovery.
// - alarm-one and alarm-two match flags set on match, cleared after read.
// - two scratch bits in status one store and return host data.
// - hour-format bit: zero selects 12-hour, one selects 24-hour.
// - writing one to the init bit initializes; it always reads zero.
// - three status-two bits select pin-two mode; none, or alarm-two interrupt.
// - frequency, per-minute edge, or 50% minute-periodic modes ignore alarm enable.
// - scratch bit in status two stores and returns host data.
// - alarm one runs only in its enable mode; otherwise a storage byte.
// - alarm registers hold weekday, hour, minute bytes in live-time layout.
// - bit zero of each alarm byte enables that byte's compare.
// - pin two carries both frequency output and alarm-two interrupt.
// - frequency mode output is the AND of enabled 1 to 16 Hz.
// - low three frequency-register bits are scratch storage in that mode.
// - the 1 Hz component stays aligned with the seconds counter.
// - eight-bit rate-correction value held; host writes zero when unused.
// - init clears status two, alarms, correction, free; keeps status-one bits 6..4.
// - voltage detector samples 15.6 ms each second, stops once flag set.
`timescale 1ns/1ps
`default_nettype none
module rtc_status_alarm_control #(
	parameter int OSC_HZ = rtc_pkg::OSC_HZ_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic osc_clk,
	input wire logic [2:0] acc_cmd,
	input wire logic [1:0] acc_byte,
	input wire logic acc_wr,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_rd_start,
	input wire logic acc_rd_done,
	output logic [7:0] acc_rdata,
	input wire logic supply_low,
	input wire logic [7:0] cur_weekday,
	input wire logic [7:0] cur_hour,
	input wire logic [7:0] cur_minute,
	output logic hour_mode_24,
	output logic [7:0] rate_correction,
	output logic init_pulse,
	output logic alarm_two_match_flag_o,
	output logic alarm_two_match_flag_oe
);
	localparam int SW = rtc_pkg::FREQ_COUNT + 4;

	osc_time_if link ();

	rtc_time_base #(.OSC_HZ(OSC_HZ)) u_time_base (
		.osc_clk(osc_clk),
		.rst_n(rst_n),
		.link(link.src)
	);

	// status_mode_one held as separate bits
	logic power_on_flag;
	logic low_voltage_flag;
	logic alarm_one_match_flag;
	logic alarm_two_match_flag;
	logic scratch_bit_a;
	logic scratch_bit_b;
	logic hour_24;
	logic [7:0] status_mode_two;
	logic [7:0] alarm_one_time [0:rtc_pkg::ALARM_BYTES-1];
	logic [7:0] alarm_two_or_frequency [0:rtc_pkg::ALARM_BYTES-1];
	logic [7:0] free_byte;

	logic [SW-1:0] sync_a;
	logic [SW-1:0] sync_b;
	logic min_last;
	logic rd_pending;
	logic [2:0] clr_mask;
	logic alarm_two_pin_hold;
	logic edge_hold;

	// crossing from the oscillator domain and the detector pin
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync_a <= '0;
			sync_b <= '0;
			min_last <= 1'b0;
		end else begin
			sync_a <= {link.min_toggle, link.half_minute, link.freq_level, link.lv_window,
				supply_low};
			sync_b <= sync_a;
			min_last <= sync_b[SW-1];
		end
	end

	wire min_event = sync_b[SW-1] ^ min_last;
	wire half_minute_s = sync_b[SW-2];
	wire [rtc_pkg::FREQ_COUNT-1:0] freq_level_s = sync_b[SW-3 -: rtc_pkg::FREQ_COUNT];
	wire lv_window_s = sync_b[1];
	wire supply_low_s = sync_b[0];

	// access decode
	wire wr_s1 = acc_wr && (acc_cmd == rtc_pkg::CMD_STATUS_ONE);
	wire wr_s2 = acc_wr && (acc_cmd == rtc_pkg::CMD_STATUS_TWO);
	wire wr_a1 = acc_wr && (acc_cmd == rtc_pkg::CMD_ALARM_ONE);
	wire wr_a2 = acc_wr && (acc_cmd == rtc_pkg::CMD_ALARM_TWO);
	wire wr_corr = acc_wr && (acc_cmd == rtc_pkg::CMD_CORRECTION);
	wire wr_free = acc_wr && (acc_cmd == rtc_pkg::CMD_FREE);
	wire byte_ok = (acc_byte < 2'(rtc_pkg::ALARM_BYTES));
	wire init_req = wr_s1 && acc_wdata[rtc_pkg::S1_INIT];
	wire [1:0] wr_scratch = acc_wdata[rtc_pkg::S1_SCRATCH_A:rtc_pkg::S1_SCRATCH_B];

	wire a1_mode = status_mode_two[rtc_pkg::S2_A1_ENABLE]
		&& !status_mode_two[rtc_pkg::S2_A1_MINUTE]
		&& !status_mode_two[rtc_pkg::S2_A1_FREQ];
	wire o2_ae = status_mode_two[rtc_pkg::S2_OUT2_ALARM];
	wire o2_me = status_mode_two[rtc_pkg::S2_OUT2_MINUTE];
	wire o2_fe = status_mode_two[rtc_pkg::S2_OUT2_FREQ];

	rtc_pkg::out2_mode_t out2_mode;
	assign out2_mode = (o2_me && o2_fe) ? rtc_pkg::OUT2_PERIODIC :
		o2_me ? rtc_pkg::OUT2_EDGE :
		o2_fe ? rtc_pkg::OUT2_FREQ :
		o2_ae ? rtc_pkg::OUT2_ALARM : rtc_pkg::OUT2_NONE;

	function automatic logic alarm_hit(input logic [7:0] wk, input logic [7:0] hr,
		input logic [7:0] mn, input logic [7:0] lwk, input logic [7:0] lhr,
		input logic [7:0] lmn);
		logic any;
		logic same;
		any = wk[rtc_pkg::ALARM_VALID_BIT] | hr[rtc_pkg::ALARM_VALID_BIT]
			| mn[rtc_pkg::ALARM_VALID_BIT];
		same = (!wk[rtc_pkg::ALARM_VALID_BIT] || (wk[7:1] == lwk[7:1]))
			&& (!hr[rtc_pkg::ALARM_VALID_BIT] || (hr[7:1] == lhr[7:1]))
			&& (!mn[rtc_pkg::ALARM_VALID_BIT] || (mn[7:1] == lmn[7:1]));
		return any && same;
	endfunction : alarm_hit

	wire a1_hit = min_event && a1_mode && alarm_hit(alarm_one_time[0], alarm_one_time[1],
		alarm_one_time[2], cur_weekday, cur_hour, cur_minute);
	wire a2_hit = min_event && (out2_mode == rtc_pkg::OUT2_ALARM)
		&& alarm_hit(alarm_two_or_frequency[0], alarm_two_or_frequency[1],
		alarm_two_or_frequency[2], cur_weekday, cur_hour, cur_minute);

	wire lv_set = lv_window_s && supply_low_s && !low_voltage_flag;

	// clear only what was shifted out
	wire clr_now = rd_pending && acc_rd_done;

	// set wins over every clear
	wire next_power_on = power_on_flag && !init_req && !(clr_now && clr_mask[0]);
	wire next_low_volt = lv_set || (low_voltage_flag && !init_req);
	wire next_alarm_two = a2_hit
		|| (alarm_two_match_flag && !init_req && !(clr_now && clr_mask[1]));
	wire next_alarm_one = a1_hit
		|| (alarm_one_match_flag && !init_req && !(clr_now && clr_mask[2]));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			power_on_flag <= 1'b1;
			low_voltage_flag <= 1'b0;
			alarm_one_match_flag <= 1'b0;
			alarm_two_match_flag <= 1'b0;
		end else begin
			power_on_flag <= next_power_on;
			low_voltage_flag <= next_low_volt;
			alarm_one_match_flag <= next_alarm_one;
			alarm_two_match_flag <= next_alarm_two;
		end
	end

	// init keeps bits 6..4 as written
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scratch_bit_a <= 1'b0;
			scratch_bit_b <= 1'b0;
			hour_24 <= 1'b0;
		end else if (wr_s1) begin
			scratch_bit_a <= wr_scratch[1];
			scratch_bit_b <= wr_scratch[0];
			hour_24 <= acc_wdata[rtc_pkg::S1_HOUR_24];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			status_mode_two <= rtc_pkg::RST_STATUS_TWO;
			rate_correction <= rtc_pkg::RST_CORRECTION;
			free_byte <= rtc_pkg::RST_FREE;
		end else if (init_req) begin
			status_mode_two <= rtc_pkg::INIT_VALUE;
			rate_correction <= rtc_pkg::INIT_VALUE;
			free_byte <= rtc_pkg::INIT_VALUE;
		end else begin
			if (wr_s2) begin
				status_mode_two <= acc_wdata;
			end
			if (wr_corr) begin
				rate_correction <= acc_wdata;
			end
			if (wr_free) begin
				free_byte <= acc_wdata;
			end
		end
	end

	// alarm-two byte 0 doubles as the frequency register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int k = 0; k < rtc_pkg::ALARM_BYTES; k++) begin
				alarm_one_time[k] <= (k == 0) ? rtc_pkg::RST_ALARM_ONE : rtc_pkg::INIT_VALUE;
				alarm_two_or_frequency[k] <= rtc_pkg::RST_ALARM_TWO;
			end
		end else begin
			for (int k = 0; k < rtc_pkg::ALARM_BYTES; k++) begin
				if (init_req) begin
					alarm_one_time[k] <= rtc_pkg::INIT_VALUE;
					alarm_two_or_frequency[k] <= rtc_pkg::INIT_VALUE;
				end else begin
					if (wr_a1 && byte_ok && (acc_byte == 2'(k))) begin
						alarm_one_time[k] <= acc_wdata;
					end
					if (wr_a2 && byte_ok && (acc_byte == 2'(k))) begin
						alarm_two_or_frequency[k] <= acc_wdata;
					end
				end
			end
		end
	end

	// read path; init bit always reads zero
	wire [7:0] status_one_view = {1'b0, hour_24, scratch_bit_a, scratch_bit_b,
		alarm_one_match_flag, alarm_two_match_flag, low_voltage_flag, power_on_flag};
	wire [7:0] a1_byte = byte_ok ? alarm_one_time[acc_byte] : 8'h00;
	wire [7:0] a2_byte = byte_ok ? alarm_two_or_frequency[acc_byte] : 8'h00;
	wire [7:0] rd_mux = (acc_cmd == rtc_pkg::CMD_STATUS_ONE) ? status_one_view :
		(acc_cmd == rtc_pkg::CMD_STATUS_TWO) ? status_mode_two :
		(acc_cmd == rtc_pkg::CMD_ALARM_ONE) ? a1_byte :
		(acc_cmd == rtc_pkg::CMD_ALARM_TWO) ? a2_byte :
		(acc_cmd == rtc_pkg::CMD_CORRECTION) ? rate_correction :
		(acc_cmd == rtc_pkg::CMD_FREE) ? free_byte : 8'h00;
	wire rd_s1 = acc_rd_start && (acc_cmd == rtc_pkg::CMD_STATUS_ONE);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			acc_rdata <= 8'h00;
			rd_pending <= 1'b0;
			clr_mask <= 3'h0;
		end else begin
			if (acc_rd_start) begin
				acc_rdata <= rd_mux;
			end
			rd_pending <= rd_s1 || (rd_pending && !acc_rd_done);
			if (rd_s1) begin
				clr_mask <= {alarm_one_match_flag, alarm_two_match_flag, power_on_flag};
			end
		end
	end

	wire [rtc_pkg::FREQ_COUNT-1:0] freq_en =
		alarm_two_or_frequency[0][rtc_pkg::FREQ_FIELD_LSB +: rtc_pkg::FREQ_COUNT];
	wire freq_and = (|freq_en) && (&(freq_level_s | ~freq_en));

	// alarm-two interrupt held until host drops the enable
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			alarm_two_pin_hold <= 1'b0;
			edge_hold <= 1'b0;
		end else begin
			alarm_two_pin_hold <= a2_hit
				|| (alarm_two_pin_hold && (out2_mode == rtc_pkg::OUT2_ALARM));
			// edge interrupt holds until status one has been read out
			edge_hold <= (min_event && (out2_mode == rtc_pkg::OUT2_EDGE))
				|| (edge_hold && (out2_mode == rtc_pkg::OUT2_EDGE) && !clr_now);
		end
	end

	logic next_pin;
	always_comb begin
		case (out2_mode)
			rtc_pkg::OUT2_NONE: next_pin = 1'b0;
			rtc_pkg::OUT2_FREQ: next_pin = freq_and;
			rtc_pkg::OUT2_EDGE: next_pin = edge_hold;
			rtc_pkg::OUT2_PERIODIC: next_pin = half_minute_s;
			rtc_pkg::OUT2_ALARM: next_pin = alarm_two_pin_hold;
			default: next_pin = 1'b0;
		endcase
	end

	// open-drain pin pulls low while asserted
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			alarm_two_match_flag_oe <= 1'b0;
			init_pulse <= 1'b0;
		end else begin
			alarm_two_match_flag_oe <= next_pin;
			init_pulse <= init_req;
		end
	end

	assign alarm_two_match_flag_o = 1'b0;
	assign hour_mode_24 = hour_24;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_init_clears_regs: assert property (
		init_req |=> (status_mode_two == 8'h00) && (rate_correction == 8'h00)
			&& (free_byte == 8'h00) && (alarm_one_time[0] == 8'h00) && !power_on_flag)
		else $error("initialization left a register set");
	a_init_reads_zero: assert property (
		rd_s1 |=> !acc_rdata[7] && (acc_rdata[6] == $past(hour_24)))
		else $error("init bit read back as one");
	a_low_volt_sticky: assert property (
		(low_voltage_flag && !init_req) [*3] |=> low_voltage_flag)
		else $error("low voltage flag dropped without init");
	a_power_flag_read: assert property (
		(clr_now && clr_mask[0]) |=> !power_on_flag)
		else $error("power-on flag not cleared after read");
	a_alarm_one_gate: assert property (
		$rose(alarm_one_match_flag) |-> $past(a1_mode) && $past(min_event))
		else $error("alarm one fired outside its mode");
	a_freq_output: assert property (
		(out2_mode == rtc_pkg::OUT2_FREQ) |=> (alarm_two_match_flag_oe == $past(freq_and)))
		else $error("frequency output differs from enabled AND");
	a_no_interrupt: assert property (
		(out2_mode == rtc_pkg::OUT2_NONE) |=> !alarm_two_match_flag_oe)
		else $error("pin two driven with no mode");
	a_scratch_store: assert property (
		wr_s1 |=> ({scratch_bit_a, scratch_bit_b} == $past(wr_scratch)))
		else $error("scratch bits did not store written data");
	a_alarm_pin_hold: assert property (
		(alarm_two_pin_hold && (out2_mode == rtc_pkg::OUT2_ALARM)) |=> alarm_two_match_flag_oe)
		else $error("alarm two not driven on pin two");
endmodule : rtc_status_alarm_control
`default_nettype wire

//--- hw/rtc_time_base.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_time_base #(
	parameter int OSC_HZ = rtc_pkg::OSC_HZ_DEFAULT
) (
	input wire logic osc_clk,
	input wire logic rst_n,
	osc_time_if.src link
);
	localparam int CW = $clog2(OSC_HZ);
	localparam int LV_WIN = int'($ceil(rtc_pkg::LV_SAMPLE_MS * OSC_HZ / 1000.0));

	logic rst_meta;
	logic rst_osc_n;
	logic [CW-1:0] prescale;
	logic [5:0] seconds;
	logic sec_wrap;
	logic min_wrap;
	logic min_toggle;
	logic half_minute;
	logic lv_window;

	// the sys-domain reset is brought into this domain before use
	always_ff @(posedge osc_clk) begin
		rst_meta <= rst_n;
		rst_osc_n <= rst_meta;
	end

	assign sec_wrap = (prescale == CW'(OSC_HZ - 1));
	assign min_wrap = sec_wrap && (seconds == 6'(rtc_pkg::SECONDS_PER_MINUTE - 1));

	always_ff @(posedge osc_clk) begin
		if (!rst_osc_n) begin
			prescale <= '0;
			seconds <= 6'h00;
			min_toggle <= 1'b0;
			half_minute <= 1'b1;
			lv_window <= 1'b0;
		end else begin
			prescale <= sec_wrap ? '0 : CW'(prescale + 1'b1);
			if (sec_wrap) begin
				seconds <= min_wrap ? 6'h00 : 6'(seconds + 6'h01);
			end
			if (min_wrap) begin
				min_toggle <= ~min_toggle;
			end
			half_minute <= (seconds < 6'(rtc_pkg::HALF_MINUTE));
			lv_window <= (prescale < CW'(LV_WIN));
		end
	end

	assign link.min_toggle = min_toggle;
	assign link.half_minute = half_minute;
	assign link.lv_window = lv_window;

	for (genvar i = 0; i < rtc_pkg::FREQ_COUNT; i++) begin : g_freq
		assign link.freq_level[i] = ~prescale[CW - rtc_pkg::FREQ_COUNT + i];
	end
endmodule : rtc_time_base
`default_nettype wire

//--- test/rtc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] acc_rdata,
	output logic [2:0] acc_cmd,
	output logic [1:0] acc_byte,
	output logic acc_wr,
	output logic [7:0] acc_wdata,
	output logic acc_rd_start,
	output logic acc_rd_done
);
	initial begin
		acc_cmd = 3'h0;
		acc_byte = 2'h0;
		acc_wr = 1'b0;
		acc_wdata = 8'h00;
		acc_rd_start = 1'b0;
		acc_rd_done = 1'b0;
	end

	task automatic wr(input logic [2:0] cmd, input logic [1:0] idx, input logic [7:0] d);
		@(negedge sys_clk);
		acc_cmd = cmd;
		acc_byte = idx;
		acc_wdata = (cmd == rtc_pkg::CMD_STATUS_TWO) ? {d[7:1], 1'b0} : d;
		acc_wr = 1'b1;
		@(negedge sys_clk);
		acc_wr = 1'b0;
		acc_wdata = ~acc_wdata;
	endtask : wr

	// snapshot, then report the byte shifted out so read-clear can act
	task automatic rd(input logic [2:0] cmd, input logic [1:0] idx, output logic [7:0] d);
		@(negedge sys_clk);
		acc_cmd = cmd;
		acc_byte = idx;
		acc_rd_start = 1'b1;
		@(negedge sys_clk);
		acc_rd_start = 1'b0;
		@(negedge sys_clk);
		d = acc_rdata;
		acc_rd_done = 1'b1;
		@(negedge sys_clk);
		acc_rd_done = 1'b0;
	endtask : rd
endmodule : rtc_host_model
`default_nettype wire

//--- test/tb_rtc_status_alarm_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_status_alarm_control;
	logic sys_clk;
	logic osc_clk;
	logic rst_n;
	logic supply_low;
	logic [7:0] cur_minute;
	logic [2:0] acc_cmd;
	logic [1:0] acc_byte;
	logic acc_wr;
	logic [7:0] acc_wdata;
	logic acc_rd_start;
	logic acc_rd_done;
	logic [7:0] acc_rdata;
	logic hour_mode_24;
	logic [7:0] rate_correction;
	logic alarm_two_match_flag_oe;
	logic init_pulse;
	logic alarm_two_match_flag_o;
	int fail_count = 0;
	int n_tests = 0;
	logic [7:0] v;

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// unrelated phase to the system clock
	initial begin
		osc_clk = 1'b0;
		#3;
		forever #7.5 osc_clk = ~osc_clk;
	end

	rtc_host_model host (.sys_clk(sys_clk), .acc_rdata(acc_rdata), .acc_cmd(acc_cmd),
		.acc_byte(acc_byte), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
		.acc_rd_start(acc_rd_start), .acc_rd_done(acc_rd_done));

	// a detector window of four oscillator cycles outlasts one system period
	rtc_status_alarm_control #(.OSC_HZ(256)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.osc_clk(osc_clk), .acc_cmd(acc_cmd), .acc_byte(acc_byte), .acc_wr(acc_wr),
		.acc_wdata(acc_wdata), .acc_rd_start(acc_rd_start), .acc_rd_done(acc_rd_done),
		.acc_rdata(acc_rdata), .supply_low(supply_low), .cur_weekday(8'h06),
		.cur_hour(8'h0A), .cur_minute(cur_minute), .hour_mode_24(hour_mode_24),
		.rate_correction(rate_correction), .init_pulse(init_pulse), .alarm_two_match_flag_o(alarm_two_match_flag_o),
		.alarm_two_match_flag_oe(alarm_two_match_flag_oe));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic rd_check(input logic [2:0] cmd, input logic [1:0] idx, input logic [7:0] exp);
		host.rd(cmd, idx, v);
		check(v, exp);
	endtask : rd_check

	task automatic count_oe(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (alarm_two_match_flag_oe === 1'b1) hi++;
		end
	endtask : count_oe

	task automatic wait_oe(input logic val, input int lim);
		int i;
		i = 0;
		while (alarm_two_match_flag_oe !== val && i < lim) begin
			@(negedge sys_clk);
			i++;
		end
	endtask : wait_oe

	task automatic t_power_on;
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h01);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h00);
		rd_check(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h80);
		rd_check(rtc_pkg::CMD_ALARM_ONE, 2'h0, 8'h80);
		rd_check(rtc_pkg::CMD_ALARM_TWO, 2'h0, 8'h00);
		check(rate_correction, 8'h00);
	endtask : t_power_on

	task automatic t_init;
		// hour format set by the init write itself
		host.wr(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'hF0);
		check({7'h00, init_pulse}, 8'h01);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h70);
		check({7'h00, hour_mode_24}, 8'h01);
		rd_check(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h00);
		rd_check(rtc_pkg::CMD_ALARM_ONE, 2'h0, 8'h00);
	endtask : t_init

	task automatic t_storage;
		host.wr(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h30);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h30);
		check({7'h00, hour_mode_24}, 8'h00);
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h10);
		rd_check(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h10);
		host.wr(rtc_pkg::CMD_CORRECTION, 2'h0, 8'hA5);
		rd_check(rtc_pkg::CMD_CORRECTION, 2'h0, 8'hA5);
		check(rate_correction, 8'hA5);
		host.wr(rtc_pkg::CMD_ALARM_ONE, 2'h0, 8'h5A);
		rd_check(rtc_pkg::CMD_ALARM_ONE, 2'h0, 8'h5A);
		rd_check(3'h2, 2'h0, 8'h00);
	endtask : t_storage

	task automatic t_freq;
		int hi;
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h08);
		host.wr(rtc_pkg::CMD_ALARM_TWO, 2'h0, 8'h85);
		rd_check(rtc_pkg::CMD_ALARM_TWO, 2'h0, 8'h85);
		count_oe(60, hi);
		check(8'((hi > 10) && (hi < 50)), 8'h01);
		host.wr(rtc_pkg::CMD_ALARM_TWO, 2'h0, 8'h05);
		repeat (5) @(negedge sys_clk);
		count_oe(40, hi);
		check(8'(hi), 8'h00);
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h00);
		count_oe(10, hi);
		check(8'(hi), 8'h00);
	endtask : t_freq

	task automatic t_alarms;
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h22);
		host.wr(rtc_pkg::CMD_ALARM_ONE, 2'h0, 8'h00);
		host.wr(rtc_pkg::CMD_ALARM_ONE, 2'h1, 8'h0B);
		host.wr(rtc_pkg::CMD_ALARM_ONE, 2'h2, 8'h21);
		// weekday differs but its compare is off
		host.wr(rtc_pkg::CMD_ALARM_TWO, 2'h0, 8'h0C);
		host.wr(rtc_pkg::CMD_ALARM_TWO, 2'h1, 8'h00);
		host.wr(rtc_pkg::CMD_ALARM_TWO, 2'h2, 8'h21);
		wait_oe(1'b1, 6000);
		check({7'h00, alarm_two_match_flag_oe}, 8'h01);
		check({7'h00, alarm_two_match_flag_o}, 8'h00);
		repeat (3) @(negedge sys_clk);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h3C);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h30);
		check({7'h00, alarm_two_match_flag_oe}, 8'h01);
		// enables dropped after the flags were read
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h00);
		repeat (3) @(negedge sys_clk);
		check({7'h00, alarm_two_match_flag_oe}, 8'h00);
	endtask : t_alarms

	task automatic t_minute;
		// alarm enable set as well: both minute modes must ignore it
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h06);
		wait_oe(1'b1, 6000);
		check({7'h00, alarm_two_match_flag_oe}, 8'h01);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h30);
		repeat (2) @(negedge sys_clk);
		check({7'h00, alarm_two_match_flag_oe}, 8'h00);
		// still in the first half of the minute
		host.wr(rtc_pkg::CMD_STATUS_TWO, 2'h0, 8'h0E);
		repeat (5) @(negedge sys_clk);
		check({7'h00, alarm_two_match_flag_oe}, 8'h01);
	endtask : t_minute

	task automatic t_low_volt;
		int i;
		supply_low = 1'b1;
		v = 8'h00;
		for (i = 0; i < 40 && v[1] !== 1'b1; i++) host.rd(rtc_pkg::CMD_STATUS_ONE, 2'h0, v);
		check(v, 8'h32);
		supply_low = 1'b0;
		repeat (200) @(negedge sys_clk);
		rd_check(rtc_pkg::CMD_STATUS_ONE, 2'h0, 8'h32);
	endtask : t_low_volt

	task automatic wrap_up;
		$display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		rst_n = 1'b0;
		supply_low = 1'b0;
		cur_minute = 8'h20;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		t_power_on();
		t_init();
		t_storage();
		t_freq();
		t_alarms();
		t_minute();
		t_low_volt();
		wrap_up();
	end

	// a minute tick needs about 4600 cycles; two are awaited
	initial begin
		#(50 * 20000);
		fail_count++;
		wrap_up();
	end
endmodule : tb_rtc_status_alarm_control
`default_nettype wire
